// File: core/bst_pkg.sv
// Shared constants, states and carriers of the boundary-scan test access port.
package bst_pkg;

  // ----------------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------------
  localparam int unsigned BST_IR_W = 5;
  localparam int unsigned BST_ID_W = 32;
  localparam int unsigned BST_NPIN = 8;
  localparam int unsigned BST_BSR_W = 2 * BST_NPIN;
  localparam int unsigned BST_SYNC_W = 4;

  // ----------------------------------------------------------------------
  // Instruction codes and capture values
  // ----------------------------------------------------------------------
  localparam logic [BST_IR_W-1:0] BST_IR_EXTEST = 5'h00;
  localparam logic [BST_IR_W-1:0] BST_IR_IDCODE = 5'h01;
  localparam logic [BST_IR_W-1:0] BST_IR_SAMPLE = 5'h02;
  localparam logic [BST_IR_W-1:0] BST_IR_HIGHZ = 5'h05;
  localparam logic [BST_IR_W-1:0] BST_IR_BYPASS = 5'h1f;
  localparam logic [BST_IR_W-1:0] BST_IR_CAPTURE = 5'h01;

  // TAP controller states.
  typedef enum logic [3:0] {
    BST_TLR, BST_RTI, BST_SEL_DR, BST_CAP_DR, BST_SH_DR, BST_EX1_DR, BST_PA_DR,
    BST_EX2_DR, BST_UPD_DR, BST_SEL_IR, BST_CAP_IR, BST_SH_IR, BST_EX1_IR,
    BST_PA_IR, BST_EX2_IR, BST_UPD_IR
  } bst_tap_e;

  // Data register placed between the serial input and output.
  typedef enum logic [1:0] {
    BST_SEL_BSR, BST_SEL_ID, BST_SEL_BYP
  } bst_sel_e;

  // Test port pins seen by the device.
  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
    logic trst_n;
  } bst_jtag_in_s;

  // Serial output with its enable, low while driven.
  typedef struct packed {
    logic tdo;
    logic tdo_oe_n;
  } bst_jtag_out_s;

  // Whole state of the port.
  typedef struct packed {
    bst_tap_e tap;
    logic tck_q;
    logic [BST_IR_W-1:0] ir_sh;
    logic [BST_IR_W-1:0] ir;
    logic [BST_BSR_W-1:0] bsr_sh;
    logic [BST_BSR_W-1:0] bsr_upd;
    logic [BST_ID_W-1:0] id_sh;
    logic byp;
    bst_jtag_out_s jo;
    logic [BST_NPIN-1:0] pin_out;
    logic [BST_NPIN-1:0] pin_oe_n;
  } bst_state_s;

endpackage

// File: core/bst_sync.sv
// Two-stage synchroniser for levels that arrive from outside the core clock.
`timescale 1ns/100ps
`default_nettype none
module bst_sync #(
  parameter int unsigned W = 1
) (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  // Levels.
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // The first stage feeds only the second one.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      meta_q <= '0;
      sync_q <= '0;
    end else if (ce) begin
      meta_q <= din;
      sync_q <= meta_q;
    end
  end

  assign dout = sync_q;

endmodule
`default_nettype wire

// File: core/bst_tap.sv
// Boundary-scan test access port with TAP controller and data registers.
// Overview of operation
// - Five port pins; tdo is the only output.
// - TAP state advances on tck, steered by tms.
// - tdi is sampled on rising tck.
// - tdo changes on falling tck while shifting.
// - tdo floats when no shift is running.
// - Low test reset forces test-logic-reset.
// - Code 00010 samples pins and core values.
// - Sample/preload update latches the shifted boundary data.
// - Code 00000 drives pins from latched boundary data.
// - Code 11111 selects one-bit bypass register.
// - Code 00001 shifts out the identification register.
// - Code 00101 floats every system output.
// - Highz also selects the bypass register.
`timescale 1ns/100ps
`default_nettype none
module bst_tap
  import bst_pkg::*;
#(
  // Identification value; arbitrary, only bit zero is fixed.
  parameter logic [BST_ID_W-1:0] ID_VALUE = 32'h0123_4567
) (
  // Clock, reset and enable.
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  // Test port pins.
  input wire bst_jtag_in_s jtag_in,
  output bst_jtag_out_s jtag_out,
  // System logic and pins.
  input wire logic [BST_NPIN-1:0] core_out,
  input wire logic [BST_NPIN-1:0] core_oe_n,
  input wire logic [BST_NPIN-1:0] pin_in,
  output logic [BST_NPIN-1:0] pin_out,
  output logic [BST_NPIN-1:0] pin_oe_n
);

  // ----------------------------------------------------------------------
  // Decoding
  // ----------------------------------------------------------------------

  // Register chosen by an instruction; any unlisted code acts as bypass.
  function automatic bst_sel_e dec_sel(input logic [BST_IR_W-1:0] ir);
    unique case (ir)
      BST_IR_EXTEST, BST_IR_SAMPLE: dec_sel = BST_SEL_BSR;
      BST_IR_IDCODE: dec_sel = BST_SEL_ID;
      default: dec_sel = BST_SEL_BYP;
    endcase
  endfunction

  // Next TAP state for a given tms level.
  function automatic bst_tap_e tap_next(input bst_tap_e s, input logic tms);
    unique case (s)
      BST_TLR: tap_next = tms ? BST_TLR : BST_RTI;
      BST_RTI: tap_next = tms ? BST_SEL_DR : BST_RTI;
      BST_SEL_DR: tap_next = tms ? BST_SEL_IR : BST_CAP_DR;
      BST_CAP_DR: tap_next = tms ? BST_EX1_DR : BST_SH_DR;
      BST_SH_DR: tap_next = tms ? BST_EX1_DR : BST_SH_DR;
      BST_EX1_DR: tap_next = tms ? BST_UPD_DR : BST_PA_DR;
      BST_PA_DR: tap_next = tms ? BST_EX2_DR : BST_PA_DR;
      BST_EX2_DR: tap_next = tms ? BST_UPD_DR : BST_SH_DR;
      BST_UPD_DR: tap_next = tms ? BST_SEL_DR : BST_RTI;
      BST_SEL_IR: tap_next = tms ? BST_TLR : BST_CAP_IR;
      BST_CAP_IR: tap_next = tms ? BST_EX1_IR : BST_SH_IR;
      BST_SH_IR: tap_next = tms ? BST_EX1_IR : BST_SH_IR;
      BST_EX1_IR: tap_next = tms ? BST_UPD_IR : BST_PA_IR;
      BST_PA_IR: tap_next = tms ? BST_EX2_IR : BST_PA_IR;
      BST_EX2_IR: tap_next = tms ? BST_UPD_IR : BST_SH_IR;
      BST_UPD_IR: tap_next = tms ? BST_SEL_DR : BST_RTI;
    endcase
  endfunction

  // ----------------------------------------------------------------------
  // Pin synchronisation
  // ----------------------------------------------------------------------

  bst_jtag_in_s jsync;
  logic [BST_NPIN-1:0] pin_s;

  // All port pins and sampled system pins pass two flops.
  bst_sync #(.W(BST_SYNC_W + BST_NPIN)) u_sync (
    .core_clk(core_clk),
    .rst(rst),
    .ce(ce),
    .din({jtag_in, pin_in}),
    .dout({jsync, pin_s})
  );

  // ----------------------------------------------------------------------
  // State update
  // ----------------------------------------------------------------------

  bst_state_s st_q;
  bst_state_s st_d;
  logic tck_rise;
  logic tck_fall;
  bst_sel_e sel;

  // Edges of the sampled test clock and the current register choice.
  assign tck_rise = jsync.tck & ~st_q.tck_q;
  assign tck_fall = ~jsync.tck & st_q.tck_q;
  assign sel = dec_sel(st_q.ir);

  // Next state of the whole port.
  always_comb begin
    st_d = st_q;
    st_d.tck_q = jsync.tck;
    if (!jsync.trst_n) begin
      st_d.tap = BST_TLR;
    end else if (tck_rise) begin
      st_d.tap = tap_next(st_q.tap, jsync.tms);
      unique case (st_q.tap)
        BST_TLR: begin
          st_d.ir = BST_IR_IDCODE;
        end
        BST_CAP_DR: begin
          st_d.bsr_sh = {pin_s, core_out};
          st_d.id_sh = ID_VALUE;
          st_d.byp = 1'b0;
        end
        BST_SH_DR: begin
          // Serial data enters at the top on the rising edge.
          unique case (sel)
            BST_SEL_BSR: st_d.bsr_sh = {jsync.tdi, st_q.bsr_sh[BST_BSR_W-1:1]};
            BST_SEL_ID: st_d.id_sh = {jsync.tdi, st_q.id_sh[BST_ID_W-1:1]};
            BST_SEL_BYP: st_d.byp = jsync.tdi;
          endcase
        end
        BST_UPD_DR: begin
          if (sel == BST_SEL_BSR) begin
            st_d.bsr_upd = st_q.bsr_sh;
          end
        end
        BST_CAP_IR: begin
          st_d.ir_sh = BST_IR_CAPTURE;
        end
        BST_SH_IR: begin
          st_d.ir_sh = {jsync.tdi, st_q.ir_sh[BST_IR_W-1:1]};
        end
        BST_UPD_IR: begin
          st_d.ir = st_q.ir_sh;
        end
        default: begin
        end
      endcase
    end
    // Serial output moves only on the falling edge.
    if (tck_fall) begin
      if (st_q.tap == BST_SH_IR) begin
        st_d.jo = '{tdo: st_q.ir_sh[0], tdo_oe_n: 1'b0};
      end else if (st_q.tap == BST_SH_DR) begin
        unique case (sel)
          BST_SEL_BSR: st_d.jo.tdo = st_q.bsr_sh[0];
          BST_SEL_ID: st_d.jo.tdo = st_q.id_sh[0];
          BST_SEL_BYP: st_d.jo.tdo = st_q.byp;
        endcase
        st_d.jo.tdo_oe_n = 1'b0;
      end else begin
        st_d.jo.tdo_oe_n = 1'b1;
      end
    end
    // System pins follow the core unless a test instruction owns them.
    if (st_q.ir == BST_IR_HIGHZ) begin
      st_d.pin_out = core_out;
      st_d.pin_oe_n = '1;
    end else if (st_q.ir == BST_IR_EXTEST) begin
      st_d.pin_out = st_q.bsr_upd[BST_NPIN-1:0];
      st_d.pin_oe_n = '0;
    end else begin
      st_d.pin_out = core_out;
      st_d.pin_oe_n = core_oe_n;
    end
  end

  // State register; the enable freezes everything.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_q <= '{tap: BST_TLR, ir: BST_IR_IDCODE, jo: '{tdo: 1'b0, tdo_oe_n: 1'b1},
                pin_oe_n: '1, default: '0};
    end else if (ce) begin
      st_q <= st_d;
    end
  end

  assign jtag_out = st_q.jo;
  assign pin_out = st_q.pin_out;
  assign pin_oe_n = st_q.pin_oe_n;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence s_upd_bsr;
    ce && jsync.trst_n && tck_rise && st_q.tap == BST_UPD_DR && sel == BST_SEL_BSR;
  endsequence

  sequence s_cap_dr;
    ce && jsync.trst_n && tck_rise && st_q.tap == BST_CAP_DR;
  endsequence

  property p_trst_tlr;
    ce && !jsync.trst_n |=> st_q.tap == BST_TLR;
  endproperty
  a_trst_tlr: assert property (p_trst_tlr) else $error("Test reset missed TLR.");

  property p_tap_on_rise;
    $changed(st_q.tap) |-> $past(ce && (tck_rise || !jsync.trst_n));
  endproperty
  a_tap_on_rise: assert property (p_tap_on_rise) else $error("TAP moved off edge.");

  property p_tdo_on_fall;
    $changed(jtag_out) |-> $past(ce && tck_fall);
  endproperty
  a_tdo_on_fall: assert property (p_tdo_on_fall) else $error("tdo changed off fall.");

  property p_tdo_float;
    ce && tck_fall && st_q.tap != BST_SH_DR && st_q.tap != BST_SH_IR |=> jtag_out.tdo_oe_n;
  endproperty
  a_tdo_float: assert property (p_tdo_float) else $error("tdo driven when idle.");

  property p_bypass_bit;
    ce && jsync.trst_n && tck_rise && st_q.tap == BST_SH_DR && sel == BST_SEL_BYP
      |=> st_q.byp == $past(jsync.tdi);
  endproperty
  a_bypass_bit: assert property (p_bypass_bit) else $error("Bypass bit not sampled.");

  // The bypass stage reaches tdo on the falling edge that follows its capture.
  property p_byp_out;
    ce && tck_fall && st_q.tap == BST_SH_DR && sel == BST_SEL_BYP
      |=> jtag_out.tdo == $past(st_q.byp);
  endproperty
  a_byp_out: assert property (p_byp_out) else $error("Bypass bit not shifted out.");

  property p_cap_id;
    s_cap_dr |=> st_q.id_sh == ID_VALUE && st_q.id_sh[0];
  endproperty
  a_cap_id: assert property (p_cap_id) else $error("Identification not captured.");

  property p_cap_bsr;
    s_cap_dr |=> st_q.bsr_sh == $past({pin_s, core_out});
  endproperty
  a_cap_bsr: assert property (p_cap_bsr) else $error("Boundary snapshot wrong.");

  property p_upd_bsr;
    s_upd_bsr |=> st_q.bsr_upd == $past(st_q.bsr_sh);
  endproperty
  a_upd_bsr: assert property (p_upd_bsr) else $error("Boundary update missed.");

  property p_extest_pins;
    ce && st_q.ir == BST_IR_EXTEST |=> pin_out == $past(st_q.bsr_upd[BST_NPIN-1:0]);
  endproperty
  a_extest_pins: assert property (p_extest_pins) else $error("Extest pins wrong.");

  property p_highz_pins;
    ce && st_q.ir == BST_IR_HIGHZ |=> pin_oe_n == '1;
  endproperty
  a_highz_pins: assert property (p_highz_pins) else $error("Highz left a pin driven.");

endmodule
`default_nettype wire

// File: verification/bst_tester.sv
// Behavioural board test controller that drives the test port of the device.
`timescale 1ns/100ps
`default_nettype none
module bst_tester
  import bst_pkg::*;
(
  // Test port pins towards the device.
  output var bst_jtag_in_s jtag_in,
  // Serial answer from the device.
  input wire bst_jtag_out_s jtag_out
);
  localparam realtime HALF = 62.5;

  // -----------------------------------------------------------------------
  // Pin handling
  // -----------------------------------------------------------------------
  // Idle levels: test clock parked low, the other lines at their pull-up level.
  initial begin
    jtag_in = '{tck: 1'b0, tms: 1'b1, tdi: 1'b1, trst_n: 1'b1};
  end

  // One test clock period; lines change in the low phase, the answer is taken before the rise.
  task automatic step(input logic tms, input logic tdi, output logic tdo);
    // Non-blocking updates keep a pin change that lands on a core clock edge out of a race.
    jtag_in.tms <= tms;
    jtag_in.tdi <= tdi;
    #HALF;
    tdo = jtag_out.tdo_oe_n ? 1'b1 : jtag_out.tdo;
    jtag_in.tck <= 1'b1;
    #HALF;
    jtag_in.tck <= 1'b0;
  endtask

  // Full scan from run-test-idle back to run-test-idle, first bit in and out at bit zero.
  task automatic scan(input bit ir, input int n, input logic [31:0] din, output logic [31:0] dout);
    logic t;
    dout = '0;
    step(1'b1, 1'b1, t);
    if (ir) step(1'b1, 1'b1, t);
    step(1'b0, 1'b1, t);
    step(1'b0, 1'b1, t);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], t);
      dout[i] = t;
    end
    step(1'b1, 1'b1, t);
    step(1'b0, 1'b1, t);
  endtask

  // Puts the controller in reset, by the reset pin or by five clocks with mode select high.
  task automatic reset_tap(input bit hard);
    logic t;
    if (hard) begin
      jtag_in.trst_n <= 1'b0;
      #100;
      jtag_in.trst_n <= 1'b1;
      #100;
    end else
      repeat (5) step(1'b1, 1'b1, t);
    step(1'b0, 1'b1, t);
  endtask
endmodule
`default_nettype wire

// File: verification/tb_top.sv
// Self-checking testbench of the boundary-scan test access port.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import bst_pkg::*;
  // Arbitrary identification value, bit zero set.
  localparam logic [31:0] ID = 32'h8e5a_c3b1;

  logic core_clk = 1'b0;
  logic rst;
  logic ce;
  bst_jtag_in_s jtag_in;
  bst_jtag_out_s jtag_out;
  logic [7:0] core_out;
  logic [7:0] core_oe_n;
  logic [7:0] pin_in;
  logic [7:0] pin_out;
  logic [7:0] pin_oe_n;
  int n_errors = 0;
  int total_checks = 0;

  // -----------------------------------------------------------------------
  // Clock, device and tester
  // -----------------------------------------------------------------------
  // Core clock of 8 ns.
  always #4 core_clk = ~core_clk;

  bst_tap #(.ID_VALUE(ID)) dut (.core_clk(core_clk), .rst(rst), .ce(ce), .jtag_in(jtag_in),
    .jtag_out(jtag_out), .core_out(core_out), .core_oe_n(core_oe_n), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe_n(pin_oe_n));

  bst_tester tester (.jtag_in(jtag_in), .jtag_out(jtag_out));

  // -----------------------------------------------------------------------
  // Checking and closing
  // -----------------------------------------------------------------------
  // Compares one value and reports a mismatch at once.
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic report_and_stop();
    $display("Checks made %0d, mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // -----------------------------------------------------------------------
  // Scenarios
  // -----------------------------------------------------------------------
  // Identification register is selected after reset and shifts out whole.
  task automatic t_idcode();
    logic [31:0] d;
    check("tdo_idle", jtag_out.tdo_oe_n, 32'h1);
    tester.scan(1'b0, 32, 32'h0, d);
    check("idcode", d, ID);
    check("tdo_idle_after", jtag_out.tdo_oe_n, 32'h1);
  endtask

  // Bypass, an unlisted code and highz all give one stage of delay.
  task automatic t_bypass();
    logic [31:0] d;
    logic [4:0] codes [3];
    codes = '{BST_IR_BYPASS, 5'h0a, BST_IR_HIGHZ};
    foreach (codes[k]) begin
      tester.scan(1'b1, 5, {27'h0, codes[k]}, d);
      check("ir_capture", d, 32'h1);
      check("pin_oe_n", pin_oe_n, codes[k] == BST_IR_HIGHZ ? 32'hff : 32'h0f);
      tester.scan(1'b0, 8, 32'hb5, d);
      check("bypass_out", d, 32'h6a);
    end
  endtask

  // Snapshot without disturbing the pins, then preloaded data driven under extest.
  task automatic t_sample_extest();
    logic [31:0] d;
    tester.scan(1'b1, 5, {27'h0, BST_IR_SAMPLE}, d);
    tester.scan(1'b0, 16, 32'h7e81, d);
    check("sample_snapshot", d, {16'h0, pin_in, core_out});
    check("pin_out_user", pin_out, {24'h0, core_out});
    check("pin_oe_user", pin_oe_n, {24'h0, core_oe_n});
    tester.scan(1'b1, 5, {27'h0, BST_IR_EXTEST}, d);
    check("pin_out_extest", pin_out, 32'h81);
    check("pin_oe_extest", pin_oe_n, 32'h0);
    // Enable low freezes the port, so a reset pulse and a clock pulse leave extest in force.
    @(negedge core_clk);
    ce = 1'b0;
    tester.reset_tap(1'b1);
    @(negedge core_clk);
    ce = 1'b1;
    repeat (4) @(negedge core_clk);
    check("pin_out_frozen", pin_out, 32'h81);
    check("pin_oe_frozen", pin_oe_n, 32'h0);
  endtask

  // Reset pin returns the controller to reset; the clock that follows in reset reselects the identification register.
  task automatic t_trst();
    logic [31:0] d;
    tester.reset_tap(1'b1);
    check("pin_out_after_trst", pin_out, {24'h0, core_out});
    tester.scan(1'b0, 32, 32'h0, d);
    check("id_after_trst", d, ID);
  endtask

  // -----------------------------------------------------------------------
  // Main sequence and watchdog
  // -----------------------------------------------------------------------
  // Resets the device, then runs every scenario.
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    core_out = 8'h3c;
    core_oe_n = 8'h0f;
    pin_in = 8'h96;
    repeat (12) @(posedge core_clk);
    @(negedge core_clk);
    rst = 1'b0;
    repeat (8) @(negedge core_clk);
    tester.reset_tap(1'b0);
    t_idcode();
    t_bypass();
    t_sample_extest();
    t_trst();
    report_and_stop();
  end

  // The scenarios need under 100 us; a hang is cut off well beyond that.
  initial begin
    #400000;
    n_errors++;
    report_and_stop();
  end
endmodule
`default_nettype wire
